/* bench/ubm_endpoint_bank_manager_tb.sv */
// Self-checking bench for the endpoint bank manager
`timescale 1ns/1ps
module ubm_endpoint_bank_manager_tb
  import ubm_pkg::*;
;
  logic core_clk, srst, endpoint_interrupt, usb_tok_valid, usb_tok_retry, usb_rx_valid, usb_in_ack;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, usb_tx_rd, usb_hs_valid;
  logic [7:0] s_axi_awaddr, s_axi_araddr, usb_rx_byte, usb_tx_byte;
  logic [31:0] s_axi_wdata, s_axi_rdata, rdat;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, usb_tok_kind, usb_hs_code, rsp;
  logic [6:0] usb_tx_len;
  logic [7:0] q[$];
  int n_fail, checks_done, cyc, n;
  ubm_endpoint_bank_manager ubm_endpoint_bank_manager_inst (.core_clk, .srst, .s_axi_awvalid,
    .s_axi_awready, .s_axi_awaddr, .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_araddr,
    .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp, .usb_tok_valid, .usb_tok_kind,
    .usb_tok_retry, .usb_rx_valid, .usb_rx_byte, .usb_in_ack, .usb_tx_rd, .usb_hs_valid,
    .usb_hs_code, .usb_tx_len, .usb_tx_byte, .endpoint_interrupt);
  ubm_host_model ubm_host_model_inst (.core_clk, .usb_tok_valid, .usb_tok_kind, .usb_tok_retry,
    .usb_rx_valid, .usb_rx_byte, .usb_in_ack, .usb_tx_rd, .usb_hs_valid, .usb_hs_code,
    .usb_tx_len, .usb_tx_byte);
  // ==========
  // Clock and hang guard
  always #2.5 core_clk = ~core_clk;
  always @(posedge core_clk)
  begin
    cyc++;
    if (cyc == 30000)
    begin
      n_fail++;
      tally_and_finish();
    end
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic tally_and_finish();
    if (n_fail == 0 && checks_done > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // AXI4-Lite write; each channel released at the edge it is taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic aw, w, b;
    @(posedge core_clk);
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    b = 1'b0;
    while (!b)
    begin
      @(negedge core_clk);
      aw = s_axi_awvalid & s_axi_awready;
      w = s_axi_wvalid & s_axi_wready;
      b = s_axi_bvalid;
      rsp = s_axi_bresp;
      @(posedge core_clk);
      if (aw) s_axi_awvalid <= 1'b0;
      if (w) s_axi_wvalid <= 1'b0;
      if (b) s_axi_bready <= 1'b0;
    end
  endtask
  // AXI4-Lite read into rdat and rsp
  task automatic rd(input logic [7:0] a);
    logic ar, r;
    @(posedge core_clk);
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    s_axi_araddr <= a;
    r = 1'b0;
    while (!r)
    begin
      @(negedge core_clk);
      ar = s_axi_arvalid & s_axi_arready;
      r = s_axi_rvalid;
      rdat = s_axi_rdata;
      rsp = s_axi_rresp;
      @(posedge core_clk);
      if (ar) s_axi_arvalid <= 1'b0;
      if (r) s_axi_rready <= 1'b0;
    end
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    rd(a);
    chk(rdat & m, e);
  endtask
  // ==========
  // Main sequence
  initial
  begin
    {core_clk, srst, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 7'h20;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = 52'h0000000000000F;
    {n_fail, checks_done, cyc} = '0;
    void'($urandom(36));
    repeat (5) @(posedge core_clk);
    srst <= 1'b0;
    rdc(OFF_CTRL, 32'hFFFFFFFF, 32'h0);
    rd(8'h40);
    chk(rsp, RESP_SLVERR);
    // OUT endpoint: receive, read back, free, zero-length, stall
    wr(OFF_CFG, 32'h2);
    wr(OFF_SET, 32'h2);
    n = 1 + $urandom_range(63);
    ubm_host_model_inst.pkt(TOK_OUT, 1'b0, n);
    chk(ubm_host_model_inst.hs, {1'b1, HS_ACK});
    rdc(OFF_STATE, 32'h007F0013, (n << 16) | 32'h12);
    rdc(OFF_CTRL, 32'h10, 32'h10);
    chk(endpoint_interrupt, 1'b1);
    wr(OFF_CLR, 32'h200);
    chk(endpoint_interrupt, 1'b0);
    for (int i = 0; i < n; i++)
      rdc(OFF_FIFO, 32'hFF, ubm_host_model_inst.sent[i]);
    rdc(OFF_STATE, 32'h10, 32'h0);
    wr(OFF_CLR, 32'h10);
    ubm_host_model_inst.pkt(TOK_OUT, 1'b0, 0);
    rdc(OFF_STATE, 32'h007F0002, 32'h2);
    wr(OFF_SET, 32'h4);
    ubm_host_model_inst.pkt(TOK_OUT, 1'b0, 1);
    chk(ubm_host_model_inst.hs, {1'b1, HS_STALL});
    ubm_host_model_inst.pkt(TOK_OUT, 1'b1, 0);
    chk(ubm_host_model_inst.hs, {1'b1, HS_ACK});
    wr(OFF_CLR, 32'h4);
    // IN endpoint: NAK, fill to full, release, send, compare fetched bytes
    wr(OFF_CFG, 32'h9);
    wr(OFF_CFG, 32'h1);
    ubm_host_model_inst.pkt(TOK_IN, 1'b0, 0);
    chk(ubm_host_model_inst.hs, {1'b1, HS_NAK});
    rdc(OFF_STATE, 32'h1, 32'h1);
    rdc(OFF_CTRL, 32'h10, 32'h10);
    wr(OFF_SET, 32'h1);
    chk(endpoint_interrupt, 1'b1);
    wr(OFF_CLR, 32'h100);
    chk(endpoint_interrupt, 1'b0);
    for (int i = 0; i < int'(EP_SIZE); i++)
    begin
      q.push_back(8'($urandom));
      wr(OFF_FIFO, {24'h0, q[i]});
    end
    rdc(OFF_STATE, 32'h007F0010, {9'h0, EP_SIZE, 16'h0});
    wr(OFF_CLR, 32'h10);
    ubm_host_model_inst.pkt(TOK_IN, 1'b0, 0);
    chk(ubm_host_model_inst.hs, {1'b1, HS_DATA});
    chk(usb_tx_len, EP_SIZE);
    ubm_host_model_inst.fetch(int'(EP_SIZE));
    for (int i = 0; i < int'(EP_SIZE); i++)
      chk(ubm_host_model_inst.got[i], q[i]);
    rdc(OFF_STATE, 32'h1, 32'h1);
    // Two banks: release one, the free one is taken at once, then abort
    wr(OFF_CFG, 32'hD);
    wr(OFF_CFG, 32'h5);
    wr(OFF_FIFO, 32'hA5);
    wr(OFF_CLR, 32'h100);
    wr(OFF_CLR, 32'h10);
    rdc(OFF_STATE, 32'h301, 32'h101);
    wr(OFF_CLR, 32'h1);
    rdc(OFF_STATE, 32'h300, 32'h100);
    wr(OFF_SET, 32'h8);
    do rd(OFF_CTRL); while (rdat[3] !== 1'b0);
    ubm_host_model_inst.pkt(TOK_IN, 1'b0, 0);
    chk(ubm_host_model_inst.hs, {1'b1, HS_NAK});
    // Control endpoint: SETUP under stall, flags, clear
    wr(OFF_CFG, 32'h8);
    wr(OFF_CFG, 32'h0);
    wr(OFF_SET, 32'h4);
    ubm_host_model_inst.pkt(TOK_SETUP, 1'b0, 8);
    chk(ubm_host_model_inst.hs, {1'b1, HS_ACK});
    rdc(OFF_STATE, 32'h16, 32'h4);
    rdc(OFF_CTRL, 32'h14, 32'h0);
    wr(OFF_CLR, 32'h400);
    rdc(OFF_STATE, 32'h4, 32'h0);
    tally_and_finish();
  end
endmodule // ubm_endpoint_bank_manager_tb

/* bench/ubm_host_model.sv */
// Host-side model that issues tokens, data bytes and IN fetches
`timescale 1ns/1ps
module ubm_host_model
(
  input wire logic core_clk,
  output logic usb_tok_valid,
  output logic [1:0] usb_tok_kind,
  output logic usb_tok_retry,
  output logic usb_rx_valid,
  output logic [7:0] usb_rx_byte,
  output logic usb_in_ack,
  output logic usb_tx_rd,
  input wire logic usb_hs_valid,
  input wire logic [1:0] usb_hs_code,
  input wire logic [6:0] usb_tx_len,
  input wire logic [7:0] usb_tx_byte
);
  logic [7:0] sent[$];
  logic [7:0] got[$];
  logic [2:0] hs;
  // Idle levels at time zero
  initial
  begin
    {usb_tok_valid, usb_tok_kind, usb_tok_retry, usb_rx_valid} = 5'h00;
    {usb_rx_byte, usb_in_ack, usb_tx_rd} = 10'h000;
  end
  // ==========
  // One packet: data bytes, then the token, then catch the handshake
  task automatic pkt(input logic [1:0] k, input logic rt, input int n);
    logic [7:0] b;
    b = 8'h00;
    for (int i = 0; i < n; i++)
    begin
      b = 8'($urandom);
      sent.push_back(b);
      @(posedge core_clk);
      usb_rx_valid <= 1'b1;
      usb_rx_byte <= b;
      usb_tok_kind <= k;
    end
    @(posedge core_clk);
    usb_rx_valid <= 1'b0;
    usb_rx_byte <= ~b; // Released line shows the inverse
    usb_tok_kind <= k;
    usb_tok_retry <= rt;
    usb_tok_valid <= 1'b1;
    @(posedge core_clk);
    usb_tok_valid <= 1'b0;
    usb_tok_retry <= 1'b0;
    @(negedge core_clk);
    hs = {usb_hs_valid, usb_hs_code};
    repeat (3) @(posedge core_clk);
  endtask
  // Fetch n IN bytes, then acknowledge the packet
  task automatic fetch(input int n);
    for (int i = 0; i < n; i++)
    begin
      @(posedge core_clk);
      usb_tx_rd <= 1'b1;
      @(posedge core_clk);
      usb_tx_rd <= 1'b0;
      @(negedge core_clk);
      got.push_back(usb_tx_byte);
    end
    @(posedge core_clk);
    usb_in_ack <= 1'b1;
    @(posedge core_clk);
    usb_in_ack <= 1'b0;
    repeat (3) @(posedge core_clk);
  endtask
endmodule // ubm_host_model

/* include/ubm_pkg.sv */
// Constants and types shared by the endpoint bank manager
package ubm_pkg;
  // ==========================================================
  // Bank geometry
  localparam logic [6:0] EP_SIZE = 7'h40;
  // ==========================================================
  // Register byte offsets
  localparam logic [7:0] OFF_CFG = 8'h00;
  localparam logic [7:0] OFF_CTRL = 8'h04;
  localparam logic [7:0] OFF_SET = 8'h08;
  localparam logic [7:0] OFF_CLR = 8'h0C;
  localparam logic [7:0] OFF_STATE = 8'h10;
  localparam logic [7:0] OFF_FIFO = 8'h14;
  // ==========================================================
  // Field positions
  localparam int CFG_TWO_BANK = 2;
  localparam int CFG_EP_RST = 3;
  localparam int CTL_IN_IRQ = 0;
  localparam int CTL_OUT_IRQ = 1;
  localparam int CTL_STALL = 2;
  localparam int CTL_KILL = 3;
  localparam int CTL_OWN = 4;
  localparam int CLR_IN_RDY = 8;
  localparam int CLR_OUT_RCV = 9;
  localparam int CLR_SETUP = 10;
  localparam int CLR_NAK_IN = 11;
  // ==========================================================
  // Endpoint types, token kinds, handshakes, bus answers
  localparam logic [1:0] EPT_CTRL = 2'h0;
  localparam logic [1:0] EPT_IN = 2'h1;
  localparam logic [1:0] EPT_OUT = 2'h2;
  localparam logic [1:0] TOK_SETUP = 2'h0;
  localparam logic [1:0] TOK_OUT = 2'h1;
  localparam logic [1:0] TOK_IN = 2'h2;
  localparam logic [1:0] HS_ACK = 2'h0;
  localparam logic [1:0] HS_NAK = 2'h1;
  localparam logic [1:0] HS_STALL = 2'h2;
  localparam logic [1:0] HS_DATA = 2'h3;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // ==========================================================
  // Control transfer stages
  typedef enum logic [2:0] {CS_IDLE, CS_WRITE, CS_READ, CS_STAT_IN, CS_STAT_OUT, CS_WAIT_SETUP} ubm_stage_t;
endpackage

/* rtl/ubm_endpoint_bank_manager.sv */
// Endpoint bank manager: control, IN and OUT endpoint banks behind an AXI4-Lite register port
// What this block does
// - A pending retry is answered before any stall handshake.
// - SETUP is always acknowledged; it sets the setup flag, not the OUT flag.
// - Ownership and read/write-allowed read zero on control endpoints.
// - Setup flag holds until cleared; clearing frees its bank.
// - Control OUT packet sets the OUT flag; clearing it frees the bank.
// - Control IN-ready flag set when bank free; clearing it commits the data.
// - Control write status IN may send early zero-length data, else NAK and flag.
// - Control read: first status-stage token gets a NAK.
// - Control read status: CPU data discarded, later IN-ready clear ignored.
// - OUT retry always acknowledged, setting OUT and IN-ready flags.
// - After OUT status, wait for SETUP; SETUP clears IN-ready and NAK but not the OUT flag, and loads its bytes into the FIFO.
// - Zero-length OUT packet sets byte count to zero.
// - IN endpoint: IN-ready and ownership set together when bank is free.
// - Clearing IN-ready only acknowledges; FIFO untouched.
// - Ownership clear releases IN bank and moves to next bank.
// - IN read/write-allowed stays set until bank holds endpoint size.
// - With two banks, a free next bank sets IN-ready at once.
// - Kill-bank discards the most recently released IN bank.
// - OUT endpoint: OUT flag and ownership set together when bank full.
// - OUT ownership clear frees bank; read-allowed while bank holds data.
// - Endpoint reset clears endpoint state until the reset bit is written zero.
// - Stall request set makes every following request answered with STALL, except retries and control SETUP.
`timescale 1ns/1ps
module ubm_endpoint_bank_manager
  import ubm_pkg::*;
(
  input wire logic core_clk,
  input wire logic srst,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [7:0] s_axi_araddr,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  input wire logic usb_tok_valid,
  input wire logic [1:0] usb_tok_kind,
  input wire logic usb_tok_retry,
  input wire logic usb_rx_valid,
  input wire logic [7:0] usb_rx_byte,
  input wire logic usb_in_ack,
  input wire logic usb_tx_rd,
  output logic usb_hs_valid,
  output logic [1:0] usb_hs_code,
  output logic [6:0] usb_tx_len,
  output logic [7:0] usb_tx_byte,
  output logic endpoint_interrupt
);
  // ==========================================================
  // State
  typedef struct packed {
    logic in_irq_en, out_irq_en, stall, kill;
    logic own, in_f, out_f, setup_f, nak_f, armed, dir_in;
    ubm_stage_t stage;
    logic cpu_bank, usb_bank, last_bank;
    logic [1:0] busy;
    logic [1:0][6:0] cnt;
    logic [6:0] cpu_ptr, rx_cnt, tx_ptr;
  } ubm_ep_t;

  typedef struct packed {
    logic [1:0] ep_type;
    logic two_bank, ep_rst;
    ubm_ep_t ep;
    logic hs_valid;
    logic [1:0] hs_code;
    logic [6:0] tx_len;
    logic [7:0] tx_byte;
    logic aw_have, w_have;
    logic [7:0] aw_addr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } ubm_state_t;

  ubm_state_t q;
  ubm_state_t d;
  logic [7:0] mem_q [0:2*EP_SIZE-1];

  // ==========================================================
  // Decode
  logic is_ctl, is_in, is_out, tog;
  logic wr_fire, wr_ok, rd_ok, ar_fire, cfg_fire, set_fire, clr_fire, own_clr;
  logic cpu_wr, cpu_rd, usb_wr, rx_ok, rw_allowed;
  logic [31:0] wm;
  logic [31:0] rd_val;
  logic [6:0] cur_cnt;
  logic [1:0] busy_cnt;
  logic [7:0] cpu_rbyte, tx_rbyte;

  // Endpoint type and bank stepping
  assign is_ctl = q.ep_type == EPT_CTRL;
  assign is_in = q.ep_type == EPT_IN;
  assign is_out = q.ep_type == EPT_OUT;
  assign tog = q.two_bank && !is_ctl;
  assign cur_cnt = q.ep.cnt[q.ep.cpu_bank];
  assign busy_cnt = {1'b0, q.ep.busy[0]} + {1'b0, q.ep.busy[1]};
  assign cpu_rbyte = mem_q[{q.ep.cpu_bank, q.ep.cpu_ptr[5:0]}];
  assign tx_rbyte = mem_q[{q.ep.usb_bank, q.ep.tx_ptr[5:0]}];

  // Bus decode; write data masked by byte strobes
  assign wr_fire = q.aw_have && q.w_have && !q.bvalid;
  assign wr_ok = q.aw_addr[1:0] == 2'h0 && q.aw_addr <= OFF_FIFO;
  assign rd_ok = s_axi_araddr[1:0] == 2'h0 && s_axi_araddr <= OFF_FIFO;
  assign ar_fire = s_axi_arvalid && !q.rvalid;
  assign wm = q.wdata & {{8{q.wstrb[3]}}, {8{q.wstrb[2]}}, {8{q.wstrb[1]}}, {8{q.wstrb[0]}}};
  assign cfg_fire = wr_fire && q.aw_addr == OFF_CFG;
  assign set_fire = wr_fire && q.aw_addr == OFF_SET;
  assign clr_fire = wr_fire && q.aw_addr == OFF_CLR;
  assign own_clr = clr_fire && wm[CTL_OWN] && !is_ctl && q.ep.own;

  // FIFO window access; IN side writes while not full, OUT side reads while not empty
  assign rw_allowed = !is_ctl && q.ep.own && (is_in ? cur_cnt != EP_SIZE : cur_cnt != 7'h0);
  assign cpu_wr = wr_fire && q.aw_addr == OFF_FIFO && q.wstrb[0] && !q.ep_rst && cur_cnt != EP_SIZE
                  && (is_in ? q.ep.own : is_ctl && !q.ep.armed
                  && (q.ep.stage == CS_READ || q.ep.stage == CS_WRITE || q.ep.stage == CS_STAT_IN));
  assign cpu_rd = ar_fire && s_axi_araddr == OFF_FIFO && !q.ep_rst && cur_cnt != 7'h0
                  && (is_out ? q.ep.own : is_ctl && (q.ep.out_f || q.ep.setup_f));

  // Bytes from the host land in the bank the USB side points at
  assign rx_ok = is_ctl ? (usb_tok_kind == TOK_SETUP || (!q.ep.out_f && !q.ep.stall && !usb_tok_retry))
                        : (is_out && !q.ep.busy[q.ep.usb_bank] && !q.ep.stall && !usb_tok_retry);
  assign usb_wr = usb_rx_valid && !q.ep_rst && q.ep.rx_cnt != EP_SIZE && rx_ok;

  // Register read mux
  always_comb
  begin
    case (s_axi_araddr)
      OFF_CFG: rd_val = {28'h0, q.ep_rst, q.two_bank, q.ep_type};
      OFF_CTRL: rd_val = {27'h0, q.ep.own && !is_ctl, q.ep.kill, q.ep.stall, q.ep.out_irq_en,
                          q.ep.in_irq_en};
      OFF_STATE: rd_val = {9'h0, cur_cnt, 6'h0, busy_cnt, 3'h0, rw_allowed, q.ep.nak_f, q.ep.setup_f,
                           q.ep.out_f, q.ep.in_f};
      OFF_FIFO: rd_val = cpu_rd ? {24'h0, cpu_rbyte} : 32'h0;
      default: rd_val = 32'h0;
    endcase
  end

  // ==========================================================
  // Next state: bus, software effects first, hardware events after so a set wins over a clear
  always_comb
  begin
    d = q;
    d.hs_valid = 1'b0;
    if (s_axi_awvalid && s_axi_awready)
    begin
      d.aw_have = 1'b1;
      d.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      d.w_have = 1'b1;
      d.wdata = s_axi_wdata;
      d.wstrb = s_axi_wstrb;
    end
    if (q.bvalid && s_axi_bready)
      d.bvalid = 1'b0;
    if (wr_fire)
    begin
      d.aw_have = 1'b0;
      d.w_have = 1'b0;
      d.bvalid = 1'b1;
      d.bresp = wr_ok ? RESP_OKAY : RESP_SLVERR;
    end
    if (q.rvalid && s_axi_rready)
      d.rvalid = 1'b0;
    if (ar_fire)
    begin
      d.rvalid = 1'b1;
      d.rdata = rd_val;
      d.rresp = rd_ok ? RESP_OKAY : RESP_SLVERR;
    end
    // Configuration and set register
    if (cfg_fire)
    begin
      d.ep_type = wm[1:0];
      d.two_bank = wm[CFG_TWO_BANK];
      d.ep_rst = wm[CFG_EP_RST];
    end
    if (set_fire)
    begin
      d.ep.in_irq_en = q.ep.in_irq_en | wm[CTL_IN_IRQ];
      d.ep.out_irq_en = q.ep.out_irq_en | wm[CTL_OUT_IRQ];
      d.ep.stall = q.ep.stall | wm[CTL_STALL];
      d.ep.kill = q.ep.kill | wm[CTL_KILL];
    end
    // Clear register
    if (clr_fire)
    begin
      if (wm[CTL_IN_IRQ])
        d.ep.in_irq_en = 1'b0;
      if (wm[CTL_OUT_IRQ])
        d.ep.out_irq_en = 1'b0;
      if (wm[CTL_STALL])
        d.ep.stall = 1'b0;
      if (wm[CLR_IN_RDY])
      begin
        d.ep.in_f = 1'b0;
        if (is_ctl && q.ep.in_f && q.ep.stage != CS_STAT_OUT && q.ep.stage != CS_WAIT_SETUP)
          d.ep.armed = 1'b1;
      end
      if (wm[CLR_OUT_RCV])
      begin
        d.ep.out_f = 1'b0;
        if (is_ctl && q.ep.out_f)
        begin
          d.ep.cnt[0] = 7'h0;
          d.ep.cpu_ptr = 7'h0;
        end
      end
      if (wm[CLR_SETUP])
      begin
        d.ep.setup_f = 1'b0;
        if (is_ctl && q.ep.setup_f)
        begin
          d.ep.cnt[0] = 7'h0;
          d.ep.cpu_ptr = 7'h0;
          d.ep.in_f = 1'b1;
        end
      end
      if (wm[CLR_NAK_IN])
        d.ep.nak_f = 1'b0;
    end
    // Ownership release: IN bank goes out, OUT bank is freed
    if (own_clr)
    begin
      d.ep.own = 1'b0;
      d.ep.cpu_ptr = 7'h0;
      d.ep.cpu_bank = q.ep.cpu_bank ^ tog;
      d.ep.busy[q.ep.cpu_bank] = is_in;
      if (is_in)
        d.ep.last_bank = q.ep.cpu_bank;
      else
        d.ep.cnt[q.ep.cpu_bank] = 7'h0;
    end
    // FIFO window traffic
    if (cpu_wr)
      d.ep.cnt[q.ep.cpu_bank] = cur_cnt + 7'h1;
    if (cpu_rd)
    begin
      d.ep.cnt[q.ep.cpu_bank] = cur_cnt - 7'h1;
      d.ep.cpu_ptr = q.ep.cpu_ptr + 7'h1;
    end
    if (usb_wr)
    begin
      d.ep.rx_cnt = q.ep.rx_cnt + 7'h1;
      if (q.ep.rx_cnt == 7'h0 && usb_tok_kind == TOK_SETUP)
        d.ep.dir_in = usb_rx_byte[7];
    end
    if (usb_tx_rd)
    begin
      d.tx_byte = tx_rbyte;
      d.ep.tx_ptr = q.ep.tx_ptr + 7'h1;
    end
    // Host acknowledged the IN data
    if (usb_in_ack && !q.ep_rst)
    begin
      d.ep.cnt[q.ep.usb_bank] = 7'h0;
      if (is_ctl)
      begin
        d.ep.armed = 1'b0;
        if (q.ep.stage == CS_STAT_IN)
          d.ep.stage = CS_WAIT_SETUP;
        else
          d.ep.in_f = 1'b1;
      end
      else
      begin
        d.ep.busy[q.ep.usb_bank] = 1'b0;
        d.ep.usb_bank = q.ep.usb_bank ^ tog;
      end
    end
    // Token end: choose the handshake
    if (usb_tok_valid)
    begin
      d.hs_valid = 1'b1;
      d.hs_code = HS_NAK;
      d.ep.rx_cnt = 7'h0;
      d.ep.tx_ptr = 7'h0;
      if (q.ep_rst)
        d.hs_code = HS_NAK;
      else if (is_ctl && usb_tok_kind == TOK_SETUP)
      begin
        d.hs_code = HS_ACK;
        d.ep.setup_f = 1'b1;
        d.ep.stall = 1'b0;
        d.ep.in_f = 1'b0;
        d.ep.nak_f = 1'b0;
        d.ep.armed = 1'b0;
        d.ep.cpu_ptr = 7'h0;
        d.ep.cnt[0] = q.ep.rx_cnt;
        d.ep.stage = q.ep.dir_in ? CS_READ : CS_WRITE;
      end
      else if (usb_tok_retry && usb_tok_kind != TOK_SETUP)
      begin
        d.hs_code = usb_tok_kind == TOK_IN ? HS_DATA : HS_ACK;
        if (is_ctl && usb_tok_kind == TOK_OUT)
        begin
          d.ep.out_f = 1'b1;
          d.ep.in_f = 1'b1;
        end
      end
      else if (q.ep.stall)
        d.hs_code = HS_STALL;
      else if (is_ctl)
      begin
        case (q.ep.stage)
          CS_WRITE, CS_STAT_IN:
          begin
            if (usb_tok_kind == TOK_IN)
            begin
              d.ep.stage = CS_STAT_IN;
              if (q.ep.armed)
              begin
                d.hs_code = HS_DATA;
                d.tx_len = q.ep.cnt[0];
              end
              else
                d.ep.nak_f = 1'b1;
            end
            else if (usb_tok_kind == TOK_OUT && q.ep.stage == CS_WRITE && !q.ep.out_f)
            begin
              d.hs_code = HS_ACK;
              d.ep.out_f = 1'b1;
              d.ep.cpu_ptr = 7'h0;
              d.ep.cnt[0] = q.ep.rx_cnt;
            end
          end
          CS_READ:
          begin
            if (usb_tok_kind == TOK_IN && q.ep.armed)
            begin
              d.hs_code = HS_DATA;
              d.tx_len = q.ep.cnt[0];
            end
            else if (usb_tok_kind == TOK_OUT)
            begin
              d.ep.stage = CS_STAT_OUT;
              d.ep.armed = 1'b0;
              d.ep.in_f = 1'b0;
              d.ep.cnt[0] = 7'h0;
            end
          end
          CS_STAT_OUT:
          begin
            if (usb_tok_kind == TOK_OUT)
            begin
              d.hs_code = HS_ACK;
              d.ep.out_f = 1'b1;
              d.ep.in_f = 1'b1;
              d.ep.cnt[0] = 7'h0;
              d.ep.stage = CS_WAIT_SETUP;
            end
          end
          default: d.hs_code = HS_NAK;
        endcase
      end
      else if (is_in && usb_tok_kind == TOK_IN && q.ep.busy[q.ep.usb_bank])
      begin
        d.hs_code = HS_DATA;
        d.tx_len = q.ep.cnt[q.ep.usb_bank];
      end
      else if (is_out && usb_tok_kind == TOK_OUT && !q.ep.busy[q.ep.usb_bank])
      begin
        d.hs_code = HS_ACK;
        d.ep.cnt[q.ep.usb_bank] = q.ep.rx_cnt;
        d.ep.busy[q.ep.usb_bank] = 1'b1;
        d.ep.usb_bank = q.ep.usb_bank ^ tog;
      end
    end
    // CPU takes the next bank: free for IN, full for OUT
    if (!is_ctl && !q.ep.own && !q.ep_rst && (is_in ^ q.ep.busy[q.ep.cpu_bank]) && !own_clr)
    begin
      d.ep.own = 1'b1;
      if (is_in)
        d.ep.in_f = 1'b1;
      else
        d.ep.out_f = 1'b1;
    end
    // Kill the most recently released IN bank
    if (q.ep.kill)
    begin
      d.ep.kill = 1'b0;
      if (is_in && q.ep.busy != 2'h0)
      begin
        d.ep.busy[q.ep.last_bank] = 1'b0;
        d.ep.cnt[q.ep.last_bank] = 7'h0;
        if (!q.ep.busy[!q.ep.last_bank])
          d.ep.cnt[!q.ep.last_bank] = 7'h0;
        d.ep.cpu_bank = q.ep.last_bank;
        d.ep.own = 1'b0;
        d.ep.in_f = 1'b0;
        d.ep.cpu_ptr = 7'h0;
      end
    end
    // Ownership has no meaning on a control endpoint; drop it when the type switches
    if (cfg_fire && wm[1:0] == EPT_CTRL)
      d.ep.own = 1'b0;
    // Endpoint reset holds all endpoint state cleared, configuration kept
    if (q.ep_rst)
      d.ep = '0;
  end

  // State register
  always_ff @(posedge core_clk)
  begin
    if (srst)
      q <= '0;
    else
      q <= d;
  end

  // Bank memory: CPU and USB write ports
  always_ff @(posedge core_clk)
  begin
    if (cpu_wr)
      mem_q[{q.ep.cpu_bank, cur_cnt[5:0]}] <= wm[7:0];
    if (usb_wr)
      mem_q[{q.ep.usb_bank, q.ep.rx_cnt[5:0]}] <= usb_rx_byte;
  end

  // ==========================================================
  // Outputs
  assign s_axi_awready = !q.aw_have && !q.bvalid;
  assign s_axi_wready = !q.w_have && !q.bvalid;
  assign s_axi_bvalid = q.bvalid;
  assign s_axi_bresp = q.bresp;
  assign s_axi_arready = !q.rvalid;
  assign s_axi_rvalid = q.rvalid;
  assign s_axi_rdata = q.rdata;
  assign s_axi_rresp = q.rresp;
  assign usb_hs_valid = q.hs_valid;
  assign usb_hs_code = q.hs_code;
  assign usb_tx_len = q.tx_len;
  assign usb_tx_byte = q.tx_byte;
  assign endpoint_interrupt = (q.ep.in_f && q.ep.in_irq_en)
                              || ((q.ep.out_f || q.ep.setup_f) && q.ep.out_irq_en);

  // ==========================================================
  // Checks
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (srst);

  sequence s_tok(logic [1:0] k);
    usb_tok_valid && usb_tok_kind == k && !q.ep_rst;
  endsequence
  sequence s_plain;
    !usb_tok_retry && !q.ep.stall;
  endsequence
  sequence s_release;
    own_clr && is_in && q.two_bank && !q.ep.busy[!q.ep.cpu_bank] && !q.ep.kill;
  endsequence

  setup_ack_a: assert property (s_tok(TOK_SETUP) ##0 is_ctl |=> usb_hs_valid && usb_hs_code == HS_ACK
    && q.ep.setup_f && !q.ep.stall) else $error("SETUP not acknowledged");
  retry_first_a: assert property (s_tok(TOK_OUT) ##0 (usb_tok_retry && q.ep.stall)
    |=> usb_hs_code == HS_ACK) else $error("retry lost to stall");
  stall_hs_a: assert property (s_tok(TOK_OUT) ##0 (q.ep.stall && !usb_tok_retry)
    |=> usb_hs_valid && usb_hs_code == HS_STALL) else $error("stall not returned");
  ctl_zero_a: assert property (is_ctl |-> !rw_allowed && !q.ep.own) else $error("control ownership set");
  rd_status_a: assert property (s_tok(TOK_OUT) ##0 s_plain ##0 (is_ctl && q.ep.stage == CS_READ)
    |=> usb_hs_code == HS_NAK && q.ep.stage == CS_STAT_OUT) else $error("status OUT not NAKed");
  status_drop_a: assert property (is_ctl && q.ep.stage == CS_STAT_OUT |=> !q.ep.armed)
    else $error("status stage data armed");
  zlp_count_a: assert property (s_tok(TOK_OUT) ##0 s_plain ##0 (is_out && q.ep.rx_cnt == 7'h0
    && !q.ep.busy[q.ep.usb_bank]) |=> q.ep.cnt[$past(q.ep.usb_bank)] == 7'h0) else $error("count not zero");
  in_nak_a: assert property (s_tok(TOK_IN) ##0 s_plain ##0 (is_in && q.ep.busy == 2'h0)
    |=> usb_hs_code == HS_NAK) else $error("IN without bank not NAKed");
  in_pair_a: assert property (is_in && $rose(q.ep.in_f) |-> q.ep.own) else $error("IN ready without own");
  out_pair_a: assert property (is_out && $rose(q.ep.out_f) |-> q.ep.own) else $error("OUT flag without own");
  next_bank_a: assert property (s_release |=> ##1 q.ep.own) else $error("next bank not taken");
  full_rw_a: assert property (is_in && q.ep.own && cur_cnt == EP_SIZE |-> !rw_allowed)
    else $error("write allowed when full");
endmodule // ubm_endpoint_bank_manager
